// ===== rtl/sgpf_cfg.sv
// APB register bank for tag priority map, unknown-destination forwarding and transceiver base address
// What this block does
// - Tagged frames get priority from their tag field
// - Enable bit sends unknown destinations to mask
// - Mask bits 0..2 select ports 1..3
// - Base field gives port 1 management address
// - Port 2 answers at base plus one
//
// Chosen here: the APB register port.
module sgpf_cfg #(
  parameter int NUM_PORTS = 3 // Ports covered by the forwarding mask
) (
  input wire logic pclk, // System clock, 100 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data, registered
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address, registered
  input wire logic tag_valid, // Priority lookup request
  input wire logic [sgpf_pkg::TAG_W-1:0] tag, // 802.1p tag of the frame
  output logic prio_valid, // Priority result valid
  output logic [sgpf_pkg::PRIO_W-1:0] prio, // Priority for the frame
  input wire logic lookup_valid, // Destination lookup finished
  input wire logic lookup_miss, // Destination address was not found
  input wire logic [2:0] default_ports, // Ports the engine would use otherwise
  output logic fwd_valid, // Forwarding decision valid
  output logic [2:0] fwd_ports, // Ports that get the frame
  input wire logic mgmt_valid, // Management access begins
  input wire logic [4:0] mgmt_addr, // Transceiver address of the access
  output logic mgmt_hit_valid, // Address decision valid
  output logic mgmt_hit_port1, // Access targets port 1 transceiver
  output logic mgmt_hit_port2, // Access targets port 2 transceiver
  output logic unknown_fwd_enable, // Current forwarding enable
  output logic [2:0] unknown_fwd_mask, // Current forwarding mask
  output logic [4:0] transceiver_mgmt_base // Current base address
);

  // Refuse port counts the mask layout cannot serve
  generate
    if (NUM_PORTS != sgpf_pkg::FWD_MASK_W) begin : g_bad_ports
      $error("sgpf_cfg: NUM_PORTS must equal the mask width");
    end
  endgenerate

  // Register storage
  logic [7:0] tag_priority_map_low; // Fields for tags 0..3
  logic [7:0] tag_priority_map_high; // Fields for tags 4..7
  logic [7:0] unknown_dest_forwarding; // Enable, drive, mask
  logic [7:0] transceiver_base_address; // Base address field
  logic [7:0] next_map_low;
  logic [7:0] next_map_high;
  logic [7:0] next_fwd_reg;
  logic [7:0] next_base_reg;

  // Bus response state
  logic resp_ok; // Read data for the current transfer is loaded
  logic next_resp_ok;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic addr_hit; // Address is one of the four registers
  logic [7:0] rd_mux; // Register selected by the address
  logic wr_acc; // Write takes effect at this edge

  // Datapath decision state
  logic next_fwd_valid;
  logic [2:0] next_fwd_ports;
  logic next_hit_valid;
  logic next_hit1;
  logic next_hit2;
  logic base_ok; // Base code is usable
  logic [5:0] port2_addr; // Widened so base plus one cannot wrap

  // Live field views
  assign unknown_fwd_enable = unknown_dest_forwarding[sgpf_pkg::FWD_EN_BIT];
  assign unknown_fwd_mask = unknown_dest_forwarding[sgpf_pkg::FWD_MASK_LSB +: sgpf_pkg::FWD_MASK_W];
  assign transceiver_mgmt_base = transceiver_base_address[sgpf_pkg::BASE_LSB +: sgpf_pkg::BASE_W];

  // Ready only once data is loaded, so a frozen clock enable just adds wait states
  assign pready = psel & penable & ce & resp_ok;
  assign wr_acc = pready & pwrite;

  // Address decode and read selection
  always_comb begin
    addr_hit = 1'b1;
    case (paddr)
      sgpf_pkg::ADDR_MAP_LOW: rd_mux = tag_priority_map_low;
      sgpf_pkg::ADDR_MAP_HIGH: rd_mux = tag_priority_map_high;
      sgpf_pkg::ADDR_FWD: rd_mux = unknown_dest_forwarding;
      sgpf_pkg::ADDR_BASE: rd_mux = transceiver_base_address;
      default: begin
        rd_mux = 8'h00; // Unmapped reads return zero with an error
        addr_hit = 1'b0;
      end
    endcase
  end

  // Next values of the register file; only byte lane 0 carries data
  always_comb begin
    next_map_low = tag_priority_map_low;
    next_map_high = tag_priority_map_high;
    next_fwd_reg = unknown_dest_forwarding;
    next_base_reg = transceiver_base_address;
    if (wr_acc && pstrb[0]) begin
      case (paddr)
        sgpf_pkg::ADDR_MAP_LOW: next_map_low = pwdata[7:0];
        sgpf_pkg::ADDR_MAP_HIGH: next_map_high = pwdata[7:0];
        sgpf_pkg::ADDR_FWD: begin
          // Reserved bits keep their reset value whatever is written
          next_fwd_reg = (pwdata[7:0] & sgpf_pkg::WMASK_FWD) |
                         (sgpf_pkg::RST_FWD & ~sgpf_pkg::WMASK_FWD);
        end
        sgpf_pkg::ADDR_BASE: begin
          next_base_reg = (pwdata[7:0] & sgpf_pkg::WMASK_BASE) |
                          (sgpf_pkg::RST_BASE & ~sgpf_pkg::WMASK_BASE);
        end
        default: begin
          next_map_low = tag_priority_map_low; // Unmapped write is dropped
        end
      endcase
    end
  end

  // Register file flops, reset to the documented defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_priority_map_low <= sgpf_pkg::RST_MAP_LOW;
      tag_priority_map_high <= sgpf_pkg::RST_MAP_HIGH;
      unknown_dest_forwarding <= sgpf_pkg::RST_FWD;
      transceiver_base_address <= sgpf_pkg::RST_BASE;
    end else if (ce) begin
      tag_priority_map_low <= next_map_low;
      tag_priority_map_high <= next_map_high;
      unknown_dest_forwarding <= next_fwd_reg;
      transceiver_base_address <= next_base_reg;
    end
  end

  // Bus response: load read data and error once per transfer
  always_comb begin
    next_resp_ok = resp_ok;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (!psel || pready) begin
      next_resp_ok = 1'b0; // Transfer over or idle
    end else if (!resp_ok) begin
      next_resp_ok = 1'b1;
      next_prdata = {24'h000000, rd_mux};
      next_pslverr = ~addr_hit;
    end
  end

  // Bus response flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_ok <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      resp_ok <= next_resp_ok;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Priority lookup reads the live map registers
  sgpf_prio_lookup u_prio (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .map_low(tag_priority_map_low),
    .map_high(tag_priority_map_high),
    .tag_valid(tag_valid),
    .tag(tag),
    .prio_valid(prio_valid),
    .prio(prio)
  );

  // Forwarding and management address decisions
  always_comb begin
    base_ok = (transceiver_mgmt_base != sgpf_pkg::BASE_NONE) &&
              (transceiver_mgmt_base != sgpf_pkg::BASE_TOP_A) &&
              (transceiver_mgmt_base != sgpf_pkg::BASE_TOP_B);
    port2_addr = {1'b0, transceiver_mgmt_base} + 6'h01;
    next_fwd_valid = lookup_valid;
    next_fwd_ports = fwd_ports;
    if (lookup_valid) begin
      // Mask bit i is port i+1, so the mask maps straight onto the port vector
      if (lookup_miss && unknown_fwd_enable) begin
        next_fwd_ports = unknown_fwd_mask;
      end else begin
        next_fwd_ports = default_ports; // Feature off or known destination
      end
    end
    next_hit_valid = mgmt_valid;
    next_hit1 = mgmt_hit_port1;
    next_hit2 = mgmt_hit_port2;
    if (mgmt_valid) begin
      // Unusable base codes answer nowhere rather than alias another address
      next_hit1 = base_ok && (mgmt_addr == transceiver_mgmt_base);
      next_hit2 = base_ok && ({1'b0, mgmt_addr} == port2_addr);
    end
  end

  // Decision flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid <= 1'b0;
      fwd_ports <= 3'h0;
      mgmt_hit_valid <= 1'b0;
      mgmt_hit_port1 <= 1'b0;
      mgmt_hit_port2 <= 1'b0;
    end else if (ce) begin
      fwd_valid <= next_fwd_valid;
      fwd_ports <= next_fwd_ports;
      mgmt_hit_valid <= next_hit_valid;
      mgmt_hit_port1 <= next_hit1;
      mgmt_hit_port2 <= next_hit2;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [15:0] chk_map; // Helper: both maps for the expected field
  logic [1:0] chk_field;
  assign chk_map = {tag_priority_map_high, tag_priority_map_low};
  assign chk_field = chk_map[{tag, 1'b0} +: 2];

  property p_prio_map;
    ce && tag_valid |=> prio_valid && (prio == $past(chk_field));
  endproperty
  a_prio_map: assert property (p_prio_map) else $error("priority differs from tag field");

  property p_fwd_on;
    ce && lookup_valid && lookup_miss && unknown_fwd_enable |=> fwd_valid && (fwd_ports == $past(unknown_fwd_mask));
  endproperty
  a_fwd_on: assert property (p_fwd_on) else $error("unknown frame not sent to mask");

  property p_fwd_off;
    ce && lookup_valid && !unknown_fwd_enable |=> fwd_ports == $past(default_ports);
  endproperty
  a_fwd_off: assert property (p_fwd_off) else $error("disabled feature changed ports");

  property p_mask_excl;
    ce && lookup_valid && lookup_miss && unknown_fwd_enable && !unknown_fwd_mask[2] |=> !fwd_ports[2];
  endproperty
  a_mask_excl: assert property (p_mask_excl) else $error("excluded port 3 got the frame");

  // Inclusion side of the mask: a set bit 0 must reach port 1
  property p_mask_incl;
    ce && lookup_valid && lookup_miss && unknown_fwd_enable && unknown_fwd_mask[0] |=> fwd_ports[0];
  endproperty
  a_mask_incl: assert property (p_mask_incl) else $error("included port 1 missed the frame");

  property p_port1_hit;
    ce && mgmt_valid && base_ok && (mgmt_addr == transceiver_mgmt_base) |=> mgmt_hit_port1 && !mgmt_hit_port2;
  endproperty
  a_port1_hit: assert property (p_port1_hit) else $error("port 1 address not decoded");

  // Spelled out from the codes rather than base_ok, so a broken base_ok cannot hide here
  property p_bad_base;
    ce && mgmt_valid && ((transceiver_mgmt_base == sgpf_pkg::BASE_NONE) ||
      (transceiver_mgmt_base == sgpf_pkg::BASE_TOP_A) || (transceiver_mgmt_base == sgpf_pkg::BASE_TOP_B))
      |=> !mgmt_hit_port1 && !mgmt_hit_port2;
  endproperty
  a_bad_base: assert property (p_bad_base) else $error("unusable base code answered");

  property p_port2_hit;
    ce && mgmt_valid && base_ok && ({1'b0, mgmt_addr} == port2_addr) |=> mgmt_hit_port2 && !mgmt_hit_port1;
  endproperty
  a_port2_hit: assert property (p_port2_hit) else $error("port 2 not at base plus one");

  property p_reserved_zero;
    pready && !pwrite && (paddr == sgpf_pkg::ADDR_FWD) |-> prdata[5:3] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  property p_reserved_base;
    pready && !pwrite && (paddr == sgpf_pkg::ADDR_BASE) |-> prdata[2:0] == 3'h0;
  endproperty
  a_reserved_base: assert property (p_reserved_base) else $error("base reserved bits read nonzero");

  property p_live_update;
    wr_acc && pstrb[0] && (paddr == sgpf_pkg::ADDR_FWD) ##1 ce && lookup_valid && lookup_miss && unknown_fwd_enable
      |=> fwd_ports == $past(pwdata[2:0], 2);
  endproperty
  a_live_update: assert property (p_live_update) else $error("new mask not applied");

  // A write with its strobe set lands at the access edge, ready for the next cycle
  property p_map_write;
    wr_acc && pstrb[0] && (paddr == sgpf_pkg::ADDR_MAP_LOW) |=> tag_priority_map_low == $past(pwdata[7:0]);
  endproperty
  a_map_write: assert property (p_map_write) else $error("map write did not land");

  // Coverage of the main scenarios
  c_miss_fwd: cover property (ce && lookup_valid && lookup_miss && unknown_fwd_enable ##1 fwd_valid);
  c_frozen: cover property (!ce && tag_valid);
  c_port2: cover property (mgmt_hit_valid && mgmt_hit_port2);
  c_write_base: cover property (wr_acc && (paddr == sgpf_pkg::ADDR_BASE));
  c_err: cover property (pready && pslverr);

endmodule : sgpf_cfg

// ===== rtl/sgpf_pkg.sv
// Offsets, field layouts and reset values of the priority and forwarding configuration bank
package sgpf_pkg;

  // Printed register indices; byte address is four times the index
  localparam logic [5:0] IDX_MAP_LOW = 6'h0c; // Priority map for tags 0..3
  localparam logic [5:0] IDX_MAP_HIGH = 6'h0d; // Priority map for tags 4..7
  localparam logic [5:0] IDX_FWD = 6'h0e; // Unknown-destination forwarding
  localparam logic [5:0] IDX_BASE = 6'h0f; // Transceiver management base address

  // APB byte addresses derived from the indices
  localparam logic [7:0] ADDR_MAP_LOW = {IDX_MAP_LOW, 2'h0};
  localparam logic [7:0] ADDR_MAP_HIGH = {IDX_MAP_HIGH, 2'h0};
  localparam logic [7:0] ADDR_FWD = {IDX_FWD, 2'h0};
  localparam logic [7:0] ADDR_BASE = {IDX_BASE, 2'h0};

  // Priority field geometry
  localparam int PRIO_W = 2; // Width of one priority field
  localparam int TAG_W = 3; // Width of an 802.1p tag value

  // Forwarding register fields
  localparam int FWD_EN_BIT = 7; // Unknown-destination forwarding enable
  localparam int FWD_DRIVE_BIT = 6; // Pad drive selection, stored only
  localparam int FWD_MASK_LSB = 0; // Port mask, bit 0 is port 1
  localparam int FWD_MASK_W = 3;

  // Base address register fields
  localparam int BASE_LSB = 3;
  localparam int BASE_W = 5;
  localparam logic [4:0] BASE_NONE = 5'h00; // Not applicable code
  localparam logic [4:0] BASE_TOP_A = 5'h1e; // Not applicable code
  localparam logic [4:0] BASE_TOP_B = 5'h1f; // Not applicable code

  // Reset values
  localparam logic [7:0] RST_MAP_LOW = 8'h50;
  localparam logic [7:0] RST_MAP_HIGH = 8'hfa;
  localparam logic [7:0] RST_FWD = 8'h47;
  localparam logic [7:0] RST_BASE = 8'h08;

  // Writable bits; the rest are read-only reserved bits
  localparam logic [7:0] WMASK_MAP = 8'hff;
  localparam logic [7:0] WMASK_FWD = 8'hc7;
  localparam logic [7:0] WMASK_BASE = 8'hf8;

endpackage : sgpf_pkg

// ===== rtl/sgpf_prio_lookup.sv
// Registered 802.1p tag to queue priority lookup
module sgpf_prio_lookup (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic [7:0] map_low, // Priority fields for tags 0..3
  input wire logic [7:0] map_high, // Priority fields for tags 4..7
  input wire logic tag_valid, // Lookup request
  input wire logic [sgpf_pkg::TAG_W-1:0] tag, // Tag of the frame
  output logic prio_valid, // Result valid, one cycle
  output logic [sgpf_pkg::PRIO_W-1:0] prio // Assigned priority
);

  localparam int NUM_TAGS = 1 << sgpf_pkg::TAG_W;

  logic [15:0] map_all; // Both map registers side by side
  logic [sgpf_pkg::PRIO_W-1:0] field [NUM_TAGS]; // One field per tag value
  logic next_prio_valid;
  logic [sgpf_pkg::PRIO_W-1:0] next_prio;

  assign map_all = {map_high, map_low};

  // Unpack one field per tag value
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TAGS; gi++) begin : g_field
      assign field[gi] = map_all[gi*sgpf_pkg::PRIO_W +: sgpf_pkg::PRIO_W];
    end
  endgenerate

  // Select the field of the requested tag; live registers, so a write applies at once
  always_comb begin
    next_prio_valid = tag_valid;
    next_prio = tag_valid ? field[tag] : prio; // Hold last result between lookups
  end

  // Result registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_valid <= 1'b0;
      prio <= '0;
    end else if (ce) begin
      prio_valid <= next_prio_valid;
      prio <= next_prio;
    end
  end

endmodule : sgpf_prio_lookup

// ===== tb/tb_top.sv
// Self-checking bench for the tag priority, forwarding and transceiver base register bank
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and APB master signals
  logic pclk = 1'b0;
  logic presetn = 1'b0; // Active low, held at start
  logic ce = 1'b1; // High except for one cycle near the end, where a frozen lookup request is checked
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Lookup request and result signals
  logic tag_valid = 1'b0;
  logic [2:0] tag = 3'h0;
  logic prio_valid;
  logic [1:0] prio;
  logic lookup_valid = 1'b0;
  logic lookup_miss = 1'b0;
  logic [2:0] default_ports = 3'h0;
  logic fwd_valid;
  logic [2:0] fwd_ports;
  logic mgmt_valid = 1'b0;
  logic [4:0] mgmt_addr = 5'h00;
  logic mgmt_hit_valid;
  logic mgmt_hit_port1;
  logic mgmt_hit_port2;
  logic unknown_fwd_enable;
  logic [2:0] unknown_fwd_mask;
  logic [4:0] transceiver_mgmt_base;

  // Bench copy of the programmed settings, starting at reset values
  logic [15:0] mdl_map = 16'hfa50; // Tag 7 field in the top bits
  logic mdl_en = 1'b0;
  logic [2:0] mdl_mask = 3'h7;
  logic [4:0] mdl_base = 5'h01;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0; // Hang guard

  sgpf_cfg #(.NUM_PORTS(3)) sgpf_cfg_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tag_valid(tag_valid), .tag(tag), .prio_valid(prio_valid), .prio(prio),
    .lookup_valid(lookup_valid), .lookup_miss(lookup_miss), .default_ports(default_ports),
    .fwd_valid(fwd_valid), .fwd_ports(fwd_ports), .mgmt_valid(mgmt_valid), .mgmt_addr(mgmt_addr),
    .mgmt_hit_valid(mgmt_hit_valid), .mgmt_hit_port1(mgmt_hit_port1), .mgmt_hit_port2(mgmt_hit_port2),
    .unknown_fwd_enable(unknown_fwd_enable), .unknown_fwd_mask(unknown_fwd_mask),
    .transceiver_mgmt_base(transceiver_mgmt_base)
  );

  // 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then ends the run
  task automatic tally_and_finish();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run is under 150 cycles; the ceiling leaves wide margin
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // One APB transfer; the request is held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    `CHK(pready, 1'b1)
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so the next setup never lands in the release time step
    @(posedge pclk);
  endtask : apb

  // Read one register and compare data and error flag
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp, input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    `CHK(rd, {24'h0, exp})
    `CHK(err, experr)
  endtask : reg_chk

  // Write one register and compare the error flag
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {24'h0, d}, rd, err);
    `CHK(err, experr)
  endtask : reg_wr

  // Eight lookups covering every tag, a hit and a miss, and addresses around the base
  task automatic sweep();
    logic [4:0] ma;
    logic [1:0] hit;
    logic [2:0] fx;
    for (int t = 0; t < 8; t++) begin
      ma = mdl_base + 5'(t) - 5'h2;
      hit = 2'h0;
      // Codes 0, 0x1e and 0x1f name no transceiver at all
      if (mdl_base != 5'h00 && mdl_base < 5'h1e) begin
        hit = {ma == mdl_base + 5'h1, ma == mdl_base};
      end
      fx = (t[0] && mdl_en) ? mdl_mask : 3'(~t);
      tag_valid <= 1'b1;
      tag <= 3'(t);
      lookup_valid <= 1'b1;
      lookup_miss <= t[0];
      default_ports <= 3'(~t);
      mgmt_valid <= 1'b1;
      mgmt_addr <= ma;
      @(posedge pclk);
      tag_valid <= 1'b0;
      lookup_valid <= 1'b0;
      mgmt_valid <= 1'b0;
      @(posedge pclk);
      `CHK({prio_valid, prio}, {1'b1, mdl_map[2*t +: 2]})
      `CHK({fwd_valid, fwd_ports}, {1'b1, fx})
      `CHK({mgmt_hit_valid, mgmt_hit_port2, mgmt_hit_port1}, {1'b1, hit})
      `CHK({unknown_fwd_enable, unknown_fwd_mask, transceiver_mgmt_base}, {mdl_en, mdl_mask, mdl_base})
    end
  endtask : sweep

  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values
    reg_chk(sgpf_pkg::ADDR_MAP_LOW, 8'h50, 1'b0);
    reg_chk(sgpf_pkg::ADDR_MAP_HIGH, 8'hfa, 1'b0);
    reg_chk(sgpf_pkg::ADDR_FWD, 8'h47, 1'b0);
    reg_chk(sgpf_pkg::ADDR_BASE, 8'h08, 1'b0);
    sweep();
    // New settings; software keeps the reserved bits at their reset value of zero
    reg_wr(sgpf_pkg::ADDR_MAP_LOW, 8'h1b, 1'b0);
    reg_wr(sgpf_pkg::ADDR_MAP_HIGH, 8'he4, 1'b0);
    // A miss lookup held across the write sees the new mask in the cycle after it lands
    lookup_valid <= 1'b1;
    lookup_miss <= 1'b1;
    reg_wr(sgpf_pkg::ADDR_FWD, 8'h85, 1'b0);
    lookup_valid <= 1'b0;
    @(posedge pclk);
    `CHK({fwd_valid, fwd_ports}, 4'hd)
    reg_wr(sgpf_pkg::ADDR_BASE, 8'h28, 1'b0);
    mdl_map = 16'he41b;
    mdl_en = 1'b1;
    mdl_mask = 3'h5;
    mdl_base = 5'h05;
    reg_chk(sgpf_pkg::ADDR_FWD, 8'h85, 1'b0);
    reg_chk(sgpf_pkg::ADDR_BASE, 8'h28, 1'b0);
    sweep();
    // A write with its byte strobe off leaves the register alone
    pstrb <= 4'h0;
    reg_wr(sgpf_pkg::ADDR_MAP_LOW, 8'hff, 1'b0);
    pstrb <= 4'hf;
    reg_chk(sgpf_pkg::ADDR_MAP_LOW, 8'h1b, 1'b0);
    // Unmapped word answers with an error and reads zero
    reg_wr(8'h40, 8'h12, 1'b1);
    reg_chk(8'h40, 8'h00, 1'b1);
    // Highest usable base, port 2 lands on 0x1e
    reg_wr(sgpf_pkg::ADDR_BASE, 8'he8, 1'b0);
    mdl_base = 5'h1d;
    sweep();
    // Not-applicable base code with the forwarding feature off
    reg_wr(sgpf_pkg::ADDR_BASE, 8'hf0, 1'b0);
    reg_wr(sgpf_pkg::ADDR_FWD, 8'h02, 1'b0);
    mdl_base = 5'h1e;
    mdl_en = 1'b0;
    mdl_mask = 3'h2;
    sweep();
    // Clock enable low freezes the block, so this lookup request is never taken
    ce <= 1'b0;
    tag_valid <= 1'b1;
    @(posedge pclk);
    ce <= 1'b1;
    tag_valid <= 1'b0;
    @(posedge pclk);
    `CHK(prio_valid, 1'b0)
    // Reset in mid-run restores the defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reg_chk(sgpf_pkg::ADDR_FWD, 8'h47, 1'b0);
    reg_chk(sgpf_pkg::ADDR_BASE, 8'h08, 1'b0);
    tally_and_finish();
  end

endmodule : tb_top
